// file: ulm_line_modes.sv
`timescale 1ns/10ps
`default_nettype none
`include "ulm_consts.svh"

// Function
// R01: Infrared mode sends each zero bit as a pulse of 3/16 bit time.
// R02: That pulse scheme applies at all rates up to 115.2 kbit/s.
// R03: Software picks a baud divisor keeping rate error within 1.87 percent.
// R04: Infrared receive filter is an 8-bit down counter loaded from reload.
// R05: Falling receive edge starts counting down every core clock.
// R06: Rising receive edge stops the counter and reloads it.
// R07: Counter reaching zero forces receiver input low for one bit time.
// R08: Software must program a nonzero clock ratio for infrared operation.
// R09: Line mode 0x1 selects driver-control mode with normal framing.
// R10: In driver-control mode RTS is the inverse of transmitter-empty.
// R11: Driver-control RTS stays high through a programmed timeguard.
// R12: Line mode 0x3 selects modem mode as terminal equipment.
// R13: Release command drives DTR high, assert command drives it low.
// R14: In modem mode the device drives RTS itself.
// R15: Any change on RI, DSR, DCD or CTS sets its change flag.
// R16: The four change flags clear when the status register is read.
// R17: CTS high disables transmitter after the current character finishes.
// R18: Normal channel mode: receive pin to receiver, transmitter to pin.
// R19: Echo mode repeats receive pin on transmit pin; receiver still works.
// R20: Local loopback feeds transmitter to receiver; transmit pin held high.
// R21: Remote loopback joins receive pin to transmit pin, both ends disabled.
// R22: Line mode 0x8 selects infrared modulator and demodulator.
// R23: Channel mode is two bits: normal, echo, local, remote as 0 to 3.
module ulm_line_modes #(
  parameter int DIV_W = 16
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Serial core side.
  input  wire logic        TX_BIT,
  input  wire logic        TX_BUSY,
  input  wire logic        BIT_TICK,
  input  wire logic        SAMPLE16_TICK,
  output logic             RX_BIT,
  output logic             TX_ENABLE,
  output logic             RX_ENABLE,
  // Line pins.
  input  wire logic        RXD,
  input  wire logic        CTS_N,
  input  wire logic        DSR_N,
  input  wire logic        DCD_N,
  input  wire logic        RI_N,
  output logic             TXD,
  output logic             RTS,
  output logic             DTR_N
);

  logic [3:0]  mode_q;
  logic [1:0]  chm_q;
  logic [7:0]  irfilt_q;
  logic [10:0] ratio_q;
  logic [7:0]  tguard_q;
  logic        tx_en_q;
  logic        dtr_n_q;
  logic [3:0]  chg_q;
  logic [3:0]  pin_s1_q;
  logic [3:0]  pin_s2_q;
  logic [3:0]  pin_old_q;
  logic        rxd_s1_q;
  logic        rxd_s2_q;
  logic        rxd_old_q;
  logic        tx_run_q;
  logic [7:0]  tg_cnt_q;
  logic [7:0]  irf_cnt_q;
  logic        ir_force_q;
  logic [4:0]  pulse_cnt_q;
  logic        ir_tx_q;
  logic        txd_q;
  logic        rx_bit_q;
  logic        rts_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        tx_ena_q;
  logic        rx_ena_q;
  logic [DIV_W-1:0] per_cnt_q;
  logic [DIV_W-1:0] hold_cnt_q;
  ulm_pkg::ulm_irf_t irf_state_q;

  logic acc;
  logic wr;
  logic rd;
  logic tx_empty;
  logic is_ir;
  logic cts_hi;
  ulm_pkg::ulm_channel_loop_select_t chm;

  assign acc      = PSEL && PENABLE && !pready_q;
  assign wr       = acc && PWRITE;
  assign rd       = acc && !PWRITE;
  assign is_ir    = (mode_q == `ULM_MODE_IR); // R22
  assign chm      = ulm_pkg::ulm_channel_loop_select_t'(chm_q); // R23
  assign cts_hi   = pin_s2_q[3];
  // Timeguard keeps the empty flag low so the driver stays enabled.
  assign tx_empty = !TX_BUSY && (tg_cnt_q == 8'h00); // R11

  // Synchronisers for the asynchronous pins.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1_q  <= 4'hf;
      pin_s2_q  <= 4'hf;
      pin_old_q <= 4'hf;
      rxd_s1_q  <= 1'b1;
      rxd_s2_q  <= 1'b1;
      rxd_old_q <= 1'b1;
    end else begin
      pin_s1_q  <= {CTS_N, DCD_N, DSR_N, RI_N};
      pin_s2_q  <= pin_s1_q;
      pin_old_q <= pin_s2_q;
      rxd_s1_q  <= RXD;
      rxd_s2_q  <= rxd_s1_q;
      rxd_old_q <= rxd_s2_q;
    end
  end

  // APB slave: one wait state, unmapped addresses answer with an error.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (acc) begin
        case (PADDR)
          `ULM_OFF_CMD:    pslverr_q <= !PWRITE;
          `ULM_OFF_CFG:    prdata_q  <= {16'h0000, chm_q, 10'h000, mode_q};
          `ULM_OFF_STATUS: prdata_q  <= {8'h00, pin_s2_q[3],
                                         pin_s2_q[2], pin_s2_q[1],
                                         pin_s2_q[0], chg_q[3],
                                         chg_q[2], chg_q[1], chg_q[0],
                                         6'h00, tx_empty, 7'h00,
                                         tx_en_q, 1'b0};
          `ULM_OFF_TGUARD: prdata_q  <= {24'h000000, tguard_q};
          `ULM_OFF_RATIO:  prdata_q  <= {21'h000000, ratio_q};
          `ULM_OFF_IRFILT: prdata_q  <= {24'h000000, irfilt_q};
          default:         pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_q   <= `ULM_MODE_NORMAL;
      chm_q    <= 2'h0;
      irfilt_q <= `ULM_RST_IRFILT;
      ratio_q  <= `ULM_RST_RATIO;
      tguard_q <= 8'h00;
    end else if (wr) begin
      case (PADDR)
        `ULM_OFF_CFG: begin
          mode_q <= PWDATA[`ULM_CFG_MODE_LSB +: 4]; // R09 R12 R22
          chm_q  <= PWDATA[`ULM_CFG_CHM_LSB +: 2]; // R23
        end
        `ULM_OFF_TGUARD: tguard_q <= PWDATA[7:0];
        // The ratio is only stored and read back; infrared timing does not use it.
        `ULM_OFF_RATIO:  ratio_q  <= PWDATA[10:0]; // R08
        `ULM_OFF_IRFILT: irfilt_q <= PWDATA[7:0]; // R04
        default: ;
      endcase
    end
  end

  // Terminal-ready output.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dtr_n_q <= 1'b1;
    end else if (wr && PADDR == `ULM_OFF_CMD) begin
      if (PWDATA[`ULM_CMD_TR_OFF]) begin
        dtr_n_q <= 1'b1; // R13
      end else if (PWDATA[`ULM_CMD_TR_ON]) begin
        dtr_n_q <= 1'b0; // R13
      end
    end
  end

  // Transmitter enable and modem flow control.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_en_q <= 1'b0;
    end else if (wr && PADDR == `ULM_OFF_CMD && PWDATA[`ULM_CMD_TXDIS]) begin
      tx_en_q <= 1'b0;
    end else if (wr && PADDR == `ULM_OFF_CMD && PWDATA[`ULM_CMD_TXEN]) begin
      tx_en_q <= 1'b1;
    end
  end

  // Flow-control gate only acts between characters.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_run_q <= 1'b0;
    end else if (!TX_BUSY) begin
      tx_run_q <= tx_en_q && !(mode_q == `ULM_MODE_MODEM && cts_hi); // R17
    end
  end

  // Change flags: a new change wins over a status read.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      chg_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_q[i] != pin_old_q[i]) begin
          chg_q[i] <= 1'b1; // R15
        end else if (rd && PADDR == `ULM_OFF_STATUS) begin
          chg_q[i] <= 1'b0; // R16
        end
      end
    end
  end

  // Timeguard count after the last character, in bit periods.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tg_cnt_q <= 8'h00;
    end else if (TX_BUSY) begin
      tg_cnt_q <= tguard_q;
    end else if (BIT_TICK && tg_cnt_q != 8'h00) begin
      tg_cnt_q <= tg_cnt_q - 8'h01;
    end
  end

  // Clocks since the last bit tick. The forced receive low ends when this
  // phase comes round again, so it lasts one whole bit at any divisor.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      per_cnt_q <= {DIV_W{1'b0}};
    end else if (BIT_TICK) begin
      per_cnt_q <= {DIV_W{1'b0}};
    end else begin
      per_cnt_q <= per_cnt_q + DIV_W'(1);
    end
  end

  // Infrared modulator: zero bit becomes a 3/16 bit high pulse.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pulse_cnt_q <= 5'h00;
    end else if (BIT_TICK) begin
      pulse_cnt_q <= 5'h00;
    end else if (SAMPLE16_TICK && pulse_cnt_q != 5'h10) begin
      pulse_cnt_q <= pulse_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ir_tx_q <= 1'b0;
    end else begin
      ir_tx_q <= !TX_BIT && (pulse_cnt_q < `ULM_IR_PULSE_16); // R01 R02
    end
  end

  // Infrared receive filter.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irf_state_q <= ulm_pkg::ULM_IRF_IDLE;
      irf_cnt_q   <= 8'h00;
      ir_force_q  <= 1'b0;
      hold_cnt_q  <= {DIV_W{1'b0}};
    end else begin
      case (irf_state_q)
        ulm_pkg::ULM_IRF_IDLE: begin
          irf_cnt_q  <= irfilt_q;
          ir_force_q <= 1'b0;
          if (is_ir && rxd_old_q && !rxd_s2_q) begin
            irf_state_q <= ulm_pkg::ULM_IRF_CNT; // R05
          end
        end
        ulm_pkg::ULM_IRF_CNT: begin
          if (rxd_s2_q && !rxd_old_q) begin
            irf_cnt_q   <= irfilt_q; // R06
            irf_state_q <= ulm_pkg::ULM_IRF_IDLE;
          end else if (irf_cnt_q == 8'h00) begin
            ir_force_q  <= 1'b1; // R07
            hold_cnt_q  <= per_cnt_q; // R07
            irf_state_q <= ulm_pkg::ULM_IRF_HOLD;
          end else begin
            irf_cnt_q <= irf_cnt_q - 8'h01; // R04 R05
          end
        end
        ulm_pkg::ULM_IRF_HOLD: begin
          if (per_cnt_q == hold_cnt_q) begin
            ir_force_q  <= 1'b0; // R07
            irf_state_q <= ulm_pkg::ULM_IRF_IDLE;
          end
        end
        default: irf_state_q <= ulm_pkg::ULM_IRF_IDLE;
      endcase
    end
  end

  // Channel routing and line outputs.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      txd_q    <= 1'b1;
      rx_bit_q <= 1'b1;
      tx_ena_q <= 1'b0;
      rx_ena_q <= 1'b1;
    end else begin
      tx_ena_q <= tx_run_q && chm != ulm_pkg::ULM_CH_REMOTE; // R21
      rx_ena_q <= chm != ulm_pkg::ULM_CH_REMOTE; // R21
      case (chm)
        ulm_pkg::ULM_CH_ECHO: begin
          txd_q    <= rxd_s2_q; // R19
          rx_bit_q <= rxd_s2_q; // R19
        end
        ulm_pkg::ULM_CH_LOCAL: begin
          txd_q    <= 1'b1; // R20
          rx_bit_q <= TX_BIT; // R20
        end
        ulm_pkg::ULM_CH_REMOTE: begin
          txd_q    <= rxd_s2_q; // R21
          rx_bit_q <= 1'b1;
        end
        default: begin
          txd_q    <= is_ir ? ir_tx_q : TX_BIT; // R18
          rx_bit_q <= is_ir ? !ir_force_q : rxd_s2_q; // R18
        end
      endcase
    end
  end

  // Request-to-send line.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rts_q <= 1'b0;
    end else if (mode_q == `ULM_MODE_DRIVER) begin
      rts_q <= !tx_empty; // R10 R11
    end else if (mode_q == `ULM_MODE_MODEM) begin
      rts_q <= !tx_en_q; // R14
    end else begin
      rts_q <= 1'b0;
    end
  end

  assign PRDATA    = prdata_q;
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;
  assign TXD       = txd_q;
  assign RX_BIT    = rx_bit_q;
  assign RTS       = rts_q;
  assign DTR_N     = dtr_n_q;
  assign TX_ENABLE = tx_ena_q;
  assign RX_ENABLE = rx_ena_q;

  a_dtr_release: assert property (@(posedge CLK) disable iff (RST)
    wr && PADDR == `ULM_OFF_CMD && PWDATA[`ULM_CMD_TR_OFF]
    |=> DTR_N) else $error("terminal ready not released"); // R13
  a_dtr_assert: assert property (@(posedge CLK) disable iff (RST)
    wr && PADDR == `ULM_OFF_CMD && PWDATA[`ULM_CMD_TR_ON]
    && !PWDATA[`ULM_CMD_TR_OFF] |=> !DTR_N)
    else $error("terminal ready not asserted"); // R13
  a_chg_set: assert property (@(posedge CLK) disable iff (RST)
    pin_s2_q[0] != pin_old_q[0] |=> chg_q[0])
    else $error("change flag not set"); // R15
  a_chg_clear: assert property (@(posedge CLK) disable iff (RST)
    rd && PADDR == `ULM_OFF_STATUS && pin_s2_q == pin_old_q
    |=> chg_q == 4'h0) else $error("change flags not cleared"); // R16
  a_rts_driver: assert property (@(posedge CLK) disable iff (RST)
    mode_q == `ULM_MODE_DRIVER && TX_BUSY |=> RTS)
    else $error("driver enable low while busy"); // R10
  a_local_idle: assert property (@(posedge CLK) disable iff (RST)
    chm_q == 2'h2 && $stable(chm_q) |=> TXD)
    else $error("transmit pin not idle in local loop"); // R20
  a_echo_path: assert property (@(posedge CLK) disable iff (RST)
    chm_q == 2'h1 |=> TXD == $past(rxd_s2_q))
    else $error("echo path broken"); // R19
  a_filter_force: assert property (@(posedge CLK) disable iff (RST)
    irf_state_q == ulm_pkg::ULM_IRF_CNT && irf_cnt_q == 8'h00
    && !(rxd_s2_q && !rxd_old_q) |=> ir_force_q)
    else $error("filter did not force low"); // R07
  a_filter_reload: assert property (@(posedge CLK) disable iff (RST)
    irf_state_q == ulm_pkg::ULM_IRF_CNT && rxd_s2_q && !rxd_old_q
    |=> irf_cnt_q == $past(irfilt_q)) else $error("filter not reloaded"); // R06
  a_cts_hold: assert property (@(posedge CLK) disable iff (RST)
    TX_BUSY && $past(TX_BUSY) |-> $stable(tx_run_q))
    else $error("enable changed mid character"); // R17

endmodule : ulm_line_modes
`default_nettype wire

// file: ulm_consts.svh
`ifndef ULM_CONSTS_SVH
`define ULM_CONSTS_SVH

// Register byte offsets.
`define ULM_OFF_CMD      12'h000
`define ULM_OFF_CFG      12'h004
`define ULM_OFF_STATUS   12'h014
`define ULM_OFF_TGUARD   12'h028
`define ULM_OFF_RATIO    12'h040
`define ULM_OFF_IRFILT   12'h04c

// Command bits.
`define ULM_CMD_TXEN     6
`define ULM_CMD_TXDIS    7
`define ULM_CMD_TR_ON    16
`define ULM_CMD_TR_OFF   17

// Configuration field positions.
`define ULM_CFG_MODE_LSB 0
`define ULM_CFG_CHM_LSB  14

// Line mode encodings.
`define ULM_MODE_NORMAL  4'h0
`define ULM_MODE_DRIVER  4'h1
`define ULM_MODE_MODEM   4'h3
`define ULM_MODE_IR      4'h8

// Status bit positions.
`define ULM_ST_TXRDY     1
`define ULM_ST_TX_DONE   9
`define ULM_ST_BELL_CHG  16
`define ULM_ST_RIN       20

// Reset values.
`define ULM_RST_RATIO    11'h174
`define ULM_RST_IRFILT   8'h00

// Infrared pulse width in sixteenths of a bit.
`define ULM_IR_PULSE_16  5'h03
// Highest infrared rate in bits per second.
`define ULM_IR_MAX_BPS   115200

`endif

// file: ulm_pkg.sv
package ulm_pkg;
  typedef enum logic [1:0] {
    ULM_CH_NORMAL = 2'h0,
    ULM_CH_ECHO   = 2'h1,
    ULM_CH_LOCAL  = 2'h2,
    ULM_CH_REMOTE = 2'h3
  } ulm_channel_loop_select_t;

  typedef enum logic [2:0] {
    ULM_IRF_IDLE = 3'b001,
    ULM_IRF_CNT  = 3'b010,
    ULM_IRF_HOLD = 3'b100
  } ulm_irf_t;
endpackage : ulm_pkg

// file: ulm_modem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ulm_modem_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Terminal side.
  input  wire logic dtr_n,
  output logic      rxd,
  output logic      cts_n,
  output logic      dsr_n,
  output logic      dcd_n,
  output logic      ri_n,
  // Bench commands.
  input  wire logic slow,
  input  wire logic rx_line,
  input  wire logic ri_req,
  input  wire logic dcd_req,
  input  wire logic cts_req
);
  logic [3:0] dly_q;

  // A modem answers terminal-ready only after settling, so the data-set line
  // lags; the slow setting stretches the lag to exercise late answers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly_q <= 4'h0;
      dsr_n <= 1'b1;
    end else if (dsr_n == dtr_n) begin
      dly_q <= 4'h0;
    end else if (dly_q == (slow ? 4'hf : 4'h1)) begin
      dly_q <= 4'h0;
      dsr_n <= dtr_n;
    end else begin
      dly_q <= dly_q + 4'h1;
    end
  end

  assign rxd   = rx_line;
  assign ri_n  = ~ri_req;
  assign dcd_n = ~dcd_req;
  assign cts_n = ~cts_req;
endmodule : ulm_modem_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ulm_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %0h exp %0h", $time, (a), (e)); end end
module tb;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slverr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, lfsr;
  logic        TX_BIT, TX_BUSY, BIT_TICK, SAMPLE16_TICK, RX_BIT;
  logic        TX_ENABLE, RX_ENABLE, TXD, RTS, DTR_N;
  logic        RXD, CTS_N, DSR_N, DCD_N, RI_N;
  logic        rx_line, ri_req, dcd_req, cts_req, slow;
  logic [4:0]  tick_q;
  int          err_count, tests_run, cyc, n, m, i;

  ulm_line_modes #(.DIV_W(16)) ulm_line_modes_inst (.CLK(CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_BIT(TX_BIT), .TX_BUSY(TX_BUSY), .BIT_TICK(BIT_TICK),
    .SAMPLE16_TICK(SAMPLE16_TICK), .RX_BIT(RX_BIT), .TX_ENABLE(TX_ENABLE),
    .RX_ENABLE(RX_ENABLE), .RXD(RXD), .CTS_N(CTS_N), .DSR_N(DSR_N),
    .DCD_N(DCD_N), .RI_N(RI_N), .TXD(TXD), .RTS(RTS), .DTR_N(DTR_N));
  ulm_modem_model ulm_modem_model_inst (.clk(CLK), .rst(RST), .dtr_n(DTR_N),
    .rxd(RXD), .cts_n(CTS_N), .dsr_n(DSR_N), .dcd_n(DCD_N), .ri_n(RI_N),
    .slow(slow), .rx_line(rx_line), .ri_req(ri_req), .dcd_req(dcd_req),
    .cts_req(cts_req));

  always #2.5 CLK = ~CLK;
  // Bit period of 32 clocks divides exactly, so the rate error is zero.
  always @(posedge CLK) begin
    tick_q <= tick_q + 5'h1;
    SAMPLE16_TICK <= tick_q[0];
    BIT_TICK <= (tick_q == 5'h1f);
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic exp_txd(input int md, input logic t, input logic r);
    return (md == 0) ? t : (md == 2) ? 1'b1 : r;
  endfunction : exp_txd

  task automatic wait_clk(input int k);
    repeat (k) @(posedge CLK);
  endtask : wait_clk

  task automatic wait_bit();
    do @(posedge CLK); while (BIT_TICK !== 1'b1);
  endtask : wait_bit

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // No wait count is assumed; only the cycle ceiling ends a hung access.
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic count_high(input int len, input logic rx);
    repeat (len) begin
      @(posedge CLK);
      if ((rx ? ~RX_BIT : TXD) === 1'b1) n++;
    end
  endtask : count_high

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    CLK = 0; RST = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0;
    PWDATA = 0; TX_BIT = 1; TX_BUSY = 0; rx_line = 1; ri_req = 0;
    dcd_req = 0; cts_req = 1; slow = 0; tick_q = 0; BIT_TICK = 0;
    SAMPLE16_TICK = 0; lfsr = 32'h9e92; err_count = 0; tests_run = 0;
    cyc = 0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, 12'h030, 32'h0);
    `CHK(slverr, 1'b1)
    apb(1'b0, `ULM_OFF_RATIO, 32'h0);
    `CHK(rd[10:0], `ULM_RST_RATIO)
    apb(1'b1, `ULM_OFF_CMD, 32'h1 << `ULM_CMD_TXEN);
    $display("register test done");
    for (m = 0; m < 4; m++) begin
      apb(1'b1, `ULM_OFF_CFG, 32'(m) << `ULM_CFG_CHM_LSB);
      for (i = 0; i < 6; i++) begin
        lfsr = lfsr_next(lfsr);
        TX_BIT <= lfsr[0];
        rx_line <= lfsr[1];
        wait_clk(6);
        `CHK(TXD, exp_txd(m, lfsr[0], lfsr[1]))
        if (m == 3)
          `CHK({TX_ENABLE, RX_ENABLE}, 2'b00)
        else
          `CHK(RX_BIT, (m == 2) ? lfsr[0] : lfsr[1])
      end
    end
    rx_line <= 1'b1;
    $display("channel test done");
    apb(1'b1, `ULM_OFF_CFG, 32'(`ULM_MODE_DRIVER));
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `ULM_OFF_TGUARD, 32'(2 * i));
      TX_BUSY <= 1'b1;
      wait_clk(4);
      `CHK(RTS, 1'b1)
      TX_BUSY <= 1'b0;
      wait_clk(4);
      `CHK(RTS, 1'(i))
      wait_clk(80);
      `CHK(RTS, 1'b0)
    end
    $display("driver test done");
    apb(1'b1, `ULM_OFF_CFG, 32'(`ULM_MODE_MODEM));
    wait_clk(3);
    `CHK(RTS, 1'b0)
    apb(1'b1, `ULM_OFF_CMD, 32'h1 << `ULM_CMD_TXDIS);
    wait_clk(3);
    `CHK(RTS, 1'b1)
    apb(1'b1, `ULM_OFF_CMD, 32'h1 << `ULM_CMD_TXEN);
    apb(1'b1, `ULM_OFF_CMD, 32'h1 << `ULM_CMD_TR_ON);
    wait_clk(2);
    `CHK(DTR_N, 1'b0)
    slow <= 1'b1;
    wait_clk(40);
    apb(1'b0, `ULM_OFF_STATUS, 32'h0);
    apb(1'b0, `ULM_OFF_STATUS, 32'h0);
    `CHK(rd[19:16], 4'h0)
    for (i = 0; i < 4; i++) begin
      TX_BUSY <= (i == 3);
      case (i)
        0: ri_req <= 1'b1;
        1: apb(1'b1, `ULM_OFF_CMD, 32'h1 << `ULM_CMD_TR_OFF);
        2: dcd_req <= 1'b1;
        default: cts_req <= 1'b0;
      endcase
      wait_clk(40);
      apb(1'b0, `ULM_OFF_STATUS, 32'h0);
      `CHK(rd[19:16], 4'h1 << i)
      apb(1'b0, `ULM_OFF_STATUS, 32'h0);
      `CHK(rd[19:16], 4'h0)
    end
    `CHK(DTR_N, 1'b1)
    `CHK(TX_ENABLE, 1'b1)
    TX_BUSY <= 1'b0;
    wait_clk(4);
    `CHK(TX_ENABLE, 1'b0)
    $display("modem test done");
    cts_req <= 1'b1;
    apb(1'b1, `ULM_OFF_RATIO, 32'h1);
    apb(1'b1, `ULM_OFF_IRFILT, 32'ha);
    apb(1'b1, `ULM_OFF_CFG, 32'(`ULM_MODE_IR));
    for (i = 0; i < 2; i++) begin
      TX_BIT <= 1'(i);
      wait_bit();
      wait_bit();
      n = 0;
      count_high(64, 1'b0);
      `CHK(n, i ? 0 : 12)
    end
    for (i = 0; i < 2; i++) begin
      n = 0;
      rx_line <= 1'b0;
      count_high(i ? 20 : 5, 1'b1);
      rx_line <= 1'b1;
      count_high(100, 1'b1);
      `CHK(n, i ? 32 : 0)
    end
    $display("infrared test done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
